// ===== shared/dma_seq_pkg.sv
// constants, register map and carriers of the six-channel dma sequencer
// Functional notes
// - each channel has its own high/low priority; high channels win first
// - equal-priority channels are served in rotating round-robin order
// - source and destination step on their own: inc, dec or by index
// - with auto-reinit a finished block reloads addresses and counts and goes on
// - reload registers may be rewritten anytime; they act at next block boundary
// - selector 0 uses channel-0 reload set; 1 uses each channel's own set
// - reload set selector is read/write bit 14 of priority register, reset 0
// - 8-bit frame counter, 0 is one frame, decrements on frame's last read
// - after the last frame the frame counter reloads when auto-reinit is 1
// - 16-bit element counter decrements per element read; 0FFFFh gives 65536
// - with auto-reinit the element counter reloads after the last frame
// - doubleword moves two 16-bit halves; addresses step per half, count per word
// - source and destination selectors pick element and frame index register A or B
// - every transfer but a frame's last adds the selected element index
// - a frame's last transfer adds the selected frame index instead
// - interrupt enable 0 means no interrupt whatever the mode bit says
// - autobuffering: mode 0 interrupts at full, mode 1 at half and full
// - multiframe mode 0 interrupts once when the block completes
// - multiframe mode 1 interrupts at each frame end and at block end
// - 4-bit sync event selector; code 0000b runs unsynchronised
// - 2-bit mux selector shares channel 0-3 interrupts; reset 00b deselects them
package dma_seq_pkg;
   localparam int CH_N = 6;
   // global register byte offsets
   localparam logic [8:0] OFF_PRIO = 9'h000;
   localparam logic [8:0] OFF_EIDXA = 9'h004;
   localparam logic [8:0] OFF_EIDXB = 9'h008;
   localparam logic [8:0] OFF_FIDXA = 9'h00C;
   localparam logic [8:0] OFF_FIDXB = 9'h010;
   localparam logic [8:0] OFF_STAT = 9'h014;
   // per-channel word slots, channel n sits at (n+1)*40h
   localparam logic [3:0] SLOT_SRC = 4'h0;
   localparam logic [3:0] SLOT_DST = 4'h1;
   localparam logic [3:0] SLOT_CNT = 4'h2;
   localparam logic [3:0] SLOT_SEF = 4'h3;
   localparam logic [3:0] SLOT_MODE = 4'h4;
   localparam logic [3:0] SLOT_RSRC = 4'h5;
   localparam logic [3:0] SLOT_RDST = 4'h6;
   localparam logic [3:0] SLOT_RCNT = 4'h7;
   localparam logic [3:0] SLOT_RFRM = 4'h8;
   // priority and enable register fields
   localparam int PR_SETSEL = 14;
   localparam int PR_PRIO_LO = 8;
   localparam int PR_MUX_LO = 6;
   localparam logic [15:0] PRIO_RESET = 16'h0000;
   // transfer mode register fields
   localparam int MD_AUTO = 15;
   localparam int MD_IEN = 14;
   localparam int MD_IRQM = 13;
   localparam int MD_BUFMODE = 12;
   localparam int MD_SSEL_LO = 8;
   localparam int MD_DSEL_LO = 2;
   // sync event / frame register fields
   localparam int SF_SYNC_LO = 12;
   localparam int SF_DWORD = 11;
   // index, sync event and mux selector codes
   localparam logic [2:0] IDX_HOLD = 3'h0;
   localparam logic [2:0] IDX_INC = 3'h1;
   localparam logic [2:0] IDX_DEC = 3'h2;
   localparam logic [2:0] IDX_A = 3'h3;
   localparam logic [2:0] IDX_B = 3'h4;
   localparam logic [3:0] SYNC_NONE = 4'h0;
   localparam logic [1:0] MUX_SERIAL = 2'h0;
   localparam logic [1:0] MUX_PART = 2'h1;
   localparam logic [1:0] MUX_ALL = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } eng_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic we;
      logic [15:0] data;
   } mem_req_t;

   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [15:0] wd, input logic [1:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction
endpackage

// ===== core/dma_rr_arbiter.sv
// two-level priority arbiter with round robin inside each level
`timescale 1ns/10ps
`default_nettype none
module dma_rr_arbiter #(
   parameter int N = 6
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [N-1:0] req,
   input wire logic [N-1:0] high,
   input wire logic accept,
   output logic grantValid,
   output logic [2:0] grantIdx
);
   logic [2:0] ptrHigh_reg;
   logic [2:0] ptrLow_reg;
   wire logic [N-1:0] reqHigh = req & high;
   wire logic useHigh = |reqHigh;
   wire logic [N-1:0] pool = useHigh ? reqHigh : (req & ~high);
   wire logic [2:0] ptr = useHigh ? ptrHigh_reg : ptrLow_reg;

   // search starts just after the last winner of the level
   always_comb begin
      int j;
      j = 0;
      grantValid = 1'b0;
      grantIdx = 3'h0;
      for (int k = 1; k <= N; k++) begin
         j = (int'(ptr) + k) % N;
         if (!grantValid && pool[j]) begin
            grantValid = 1'b1;
            grantIdx = 3'(j);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ptrHigh_reg <= 3'(N - 1);
         ptrLow_reg <= 3'(N - 1);
      end else if (accept && useHigh) begin
         ptrHigh_reg <= grantIdx;
      end else if (accept) begin
         ptrLow_reg <= grantIdx;
      end
   end
endmodule // dma_rr_arbiter
`default_nettype wire

// ===== core/dma_addr_step.sv
// post-transfer address adjust for one address pointer
`timescale 1ns/10ps
`default_nettype none
module dma_addr_step
   import dma_seq_pkg::*;
(
   input wire logic [15:0] addr,
   input wire logic [2:0] sel,
   input wire logic last,
   input wire logic [15:0] elemIdxA,
   input wire logic [15:0] elemIdxB,
   input wire logic [15:0] frameIdxA,
   input wire logic [15:0] frameIdxB,
   output logic [15:0] next
);
   // frame index on a frame's last transfer, element index otherwise
   wire logic [15:0] offA = last ? frameIdxA : elemIdxA;
   wire logic [15:0] offB = last ? frameIdxB : elemIdxB;
   assign next = (sel == IDX_INC) ? addr + 16'h0001 :
                 (sel == IDX_DEC) ? addr - 16'h0001 :
                 (sel == IDX_A) ? addr + offA :
                 (sel == IDX_B) ? addr + offB : addr;
endmodule // dma_addr_step
`default_nettype wire

// ===== core/dma_channel_sequencer.sv
// six-channel dma sequencer with avalon-mm register slave and memory port
`timescale 1ns/10ps
`default_nettype none
module dma_channel_sequencer
   import dma_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic memValid,
   output mem_req_t memReq,
   input wire logic memReady,
   input wire logic [15:0] memRdata,
   input wire logic [15:0] syncEvent,
   input wire logic [3:0] serialIrq,
   output logic [5:0] dmaIrq,
   output logic [3:0] sharedIrq
);
   // register state
   logic [15:0] prioEnable_reg;
   logic [15:0] elemIdxA_reg;
   logic [15:0] elemIdxB_reg;
   logic [15:0] frameIdxA_reg;
   logic [15:0] frameIdxB_reg;
   logic [15:0] srcAddr_reg [CH_N];
   logic [15:0] dstAddr_reg [CH_N];
   logic [15:0] elemCnt_reg [CH_N];
   logic [15:0] elemSize_reg [CH_N];
   logic [15:0] syncFrame_reg [CH_N];
   logic [15:0] mode_reg [CH_N];
   logic [15:0] rlSrc_reg [CH_N];
   logic [15:0] rlDst_reg [CH_N];
   logic [15:0] rlCnt_reg [CH_N];
   logic [7:0] rlFrm_reg [CH_N];
   logic [CH_N-1:0] pend_reg;
   // engine state
   eng_state_t state_reg;
   logic [2:0] chan_reg;
   logic half_reg;
   mem_req_t req_reg;
   logic frameEnd_reg;
   logic blockEnd_reg;
   logic halfPt_reg;
   logic [5:0] irq_reg;
   // bus slave state
   logic avAck_reg;
   logic [15:0] rdData_reg;
   logic [15:0] rdMux;

   // ---------------- bus decode ----------------
   wire logic avReq = avs_read | avs_write;
   wire logic wrEn = avs_write & avAck_reg;
   wire logic [1:0] be = avs_byteenable[1:0];
   wire logic [15:0] wd = avs_writedata[15:0];
   wire logic [2:0] chSlot = avs_address[8:6];
   wire logic [3:0] regSel = avs_address[5:2];
   wire logic isGlob = (chSlot == 3'h0);
   wire logic chValid = (chSlot != 3'h0) && (chSlot != 3'h7);
   wire logic [2:0] chIdx = chSlot - 3'h1;
   wire logic chWr = wrEn & chValid;
   wire logic globWr = wrEn & isGlob;

   assign avs_waitrequest = avReq & ~avAck_reg;
   assign avs_readdata = {16'h0000, rdData_reg};

   // ---------------- active channel view ----------------
   wire logic [15:0] curMode = mode_reg[chan_reg];
   wire logic [15:0] curSf = syncFrame_reg[chan_reg];
   wire logic [15:0] curCnt = elemCnt_reg[chan_reg];
   wire logic [15:0] curSize = elemSize_reg[chan_reg];
   wire logic curAuto = curMode[MD_AUTO];
   wire logic curRing = curMode[MD_BUFMODE];
   wire logic lastHalf = ~curSf[SF_DWORD] | half_reg;
   wire logic cntZero = (curCnt == 16'h0000);
   wire logic frmZero = (curSf[7:0] == 8'h00);
   wire logic readDone = (state_reg == ST_READ) & memReady;
   wire logic writeDone = (state_reg == ST_WRITE) & memReady;
   wire logic elemRead = readDone & lastHalf;
   wire logic elemWritten = writeDone & lastHalf;
   // outside autobuffering, block ends on the last element of the last frame
   wire logic blockEndNow = cntZero & frmZero & ~curRing;
   wire logic halfPtNow = ~cntZero & (curCnt == {1'b0, curSize[15:1]});
   wire logic blockDone = elemWritten & blockEnd_reg;
   wire logic [2:0] rlIdx = prioEnable_reg[PR_SETSEL] ? chan_reg : 3'h0;

   // interrupt decision for the element just written
   wire logic ringIrq = frameEnd_reg |
                        (curMode[MD_IRQM] & halfPt_reg);
   wire logic mfIrq = blockEnd_reg |
                      (curMode[MD_IRQM] & frameEnd_reg);
   wire logic irqNow = curMode[MD_IEN] &
                       (curRing ? ringIrq : mfIrq);

   // ---------------- address steppers ----------------
   logic [15:0] srcNext;
   logic [15:0] dstNext;

   dma_addr_step u_srcStep (
      .addr(srcAddr_reg[chan_reg]),
      .sel(curMode[MD_SSEL_LO +: 3]),
      .last(lastHalf & cntZero),
      .elemIdxA(elemIdxA_reg),
      .elemIdxB(elemIdxB_reg),
      .frameIdxA(frameIdxA_reg),
      .frameIdxB(frameIdxB_reg),
      .next(srcNext)
   );

   dma_addr_step u_dstStep (
      .addr(dstAddr_reg[chan_reg]),
      .sel(curMode[MD_DSEL_LO +: 3]),
      .last(lastHalf & frameEnd_reg),
      .elemIdxA(elemIdxA_reg),
      .elemIdxB(elemIdxB_reg),
      .frameIdxA(frameIdxA_reg),
      .frameIdxB(frameIdxB_reg),
      .next(dstNext)
   );

   // ---------------- sync and request ----------------
   logic [CH_N-1:0] chReq;
   logic [CH_N-1:0] pendNext;
   logic grantValid;
   logic [2:0] grantIdx;
   wire logic accept = (state_reg == ST_IDLE) & grantValid;

   for (genvar g = 0; g < CH_N; g++) begin : g_req
      wire logic [3:0] selEv = syncFrame_reg[g][SF_SYNC_LO +: 4];
      wire logic freeRun = (selEv == SYNC_NONE);
      wire logic hit = ~freeRun & syncEvent[selEv];
      wire logic taken = accept & (grantIdx == 3'(g));
      // an event in the start cycle is kept for the next element
      assign pendNext[g] = hit | (pend_reg[g] & ~taken);
      assign chReq[g] = prioEnable_reg[g] & (freeRun | pend_reg[g]);
   end

   dma_rr_arbiter #(
      .N(CH_N)
   ) u_arb (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .req(chReq),
      .high(prioEnable_reg[PR_PRIO_LO +: CH_N]),
      .accept(accept),
      .grantValid(grantValid),
      .grantIdx(grantIdx)
   );

   // ---------------- read mux ----------------
   always_comb begin
      rdMux = 16'h0000;
      if (isGlob) begin
         case (avs_address)
            OFF_PRIO: rdMux = prioEnable_reg;
            OFF_EIDXA: rdMux = elemIdxA_reg;
            OFF_EIDXB: rdMux = elemIdxB_reg;
            OFF_FIDXA: rdMux = frameIdxA_reg;
            OFF_FIDXB: rdMux = frameIdxB_reg;
            OFF_STAT: rdMux = {8'h00, half_reg, chan_reg, 2'b00, state_reg};
            default: rdMux = 16'h0000;
         endcase
      end else if (chValid) begin
         case (regSel)
            SLOT_SRC: rdMux = srcAddr_reg[chIdx];
            SLOT_DST: rdMux = dstAddr_reg[chIdx];
            SLOT_CNT: rdMux = elemCnt_reg[chIdx];
            SLOT_SEF: rdMux = syncFrame_reg[chIdx];
            SLOT_MODE: rdMux = mode_reg[chIdx];
            SLOT_RSRC: rdMux = rlSrc_reg[chIdx];
            SLOT_RDST: rdMux = rlDst_reg[chIdx];
            SLOT_RCNT: rdMux = rlCnt_reg[chIdx];
            SLOT_RFRM: rdMux = {8'h00, rlFrm_reg[chIdx]};
            default: rdMux = 16'h0000;
         endcase
      end
   end

   // one wait state: data latched in the first cycle, acked in the second
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         avAck_reg <= 1'b0;
         rdData_reg <= 16'h0000;
      end else begin
         avAck_reg <= avReq & ~avAck_reg;
         if (avReq && !avAck_reg) begin
            rdData_reg <= rdMux;
         end
      end
   end

   // ---------------- global registers ----------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prioEnable_reg <= PRIO_RESET;
         elemIdxA_reg <= 16'h0000;
         elemIdxB_reg <= 16'h0000;
         frameIdxA_reg <= 16'h0000;
         frameIdxB_reg <= 16'h0000;
      end else begin
         // a finished block without reinit switches its channel off
         if (blockDone && !curAuto) begin
            prioEnable_reg[chan_reg] <= 1'b0;
         end
         if (globWr && avs_address == OFF_PRIO) begin
            prioEnable_reg <= merge16(prioEnable_reg, wd, be);
         end
         if (globWr && avs_address == OFF_EIDXA) begin
            elemIdxA_reg <= merge16(elemIdxA_reg, wd, be);
         end
         if (globWr && avs_address == OFF_EIDXB) begin
            elemIdxB_reg <= merge16(elemIdxB_reg, wd, be);
         end
         if (globWr && avs_address == OFF_FIDXA) begin
            frameIdxA_reg <= merge16(frameIdxA_reg, wd, be);
         end
         if (globWr && avs_address == OFF_FIDXB) begin
            frameIdxB_reg <= merge16(frameIdxB_reg, wd, be);
         end
      end
   end

   // ---------------- channel registers ----------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pend_reg <= '0;
         for (int i = 0; i < CH_N; i++) begin
            srcAddr_reg[i] <= 16'h0000;
            dstAddr_reg[i] <= 16'h0000;
            elemCnt_reg[i] <= 16'h0000;
            elemSize_reg[i] <= 16'h0000;
            syncFrame_reg[i] <= 16'h0000;
            mode_reg[i] <= 16'h0000;
            rlSrc_reg[i] <= 16'h0000;
            rlDst_reg[i] <= 16'h0000;
            rlCnt_reg[i] <= 16'h0000;
            rlFrm_reg[i] <= 8'h00;
         end
      end else begin
         pend_reg <= pendNext;
         if (readDone) begin
            srcAddr_reg[chan_reg] <= srcNext;
         end
         if (writeDone) begin
            dstAddr_reg[chan_reg] <= dstNext;
         end
         if (elemRead && !cntZero) begin
            elemCnt_reg[chan_reg] <= curCnt - 16'h0001;
         end
         if (elemRead && cntZero && !blockEndNow) begin
            elemCnt_reg[chan_reg] <= curSize;
         end
         if (elemRead && cntZero && !frmZero && !curRing) begin
            syncFrame_reg[chan_reg][7:0] <= curSf[7:0] - 8'h01;
         end
         // block boundary: the reload set takes over
         if (blockDone && curAuto) begin
            srcAddr_reg[chan_reg] <= rlSrc_reg[rlIdx];
            dstAddr_reg[chan_reg] <= rlDst_reg[rlIdx];
            elemCnt_reg[chan_reg] <= rlCnt_reg[rlIdx];
            elemSize_reg[chan_reg] <= rlCnt_reg[rlIdx];
            syncFrame_reg[chan_reg][7:0] <= rlFrm_reg[rlIdx];
         end
         if (chWr) begin
            case (regSel)
               SLOT_SRC: srcAddr_reg[chIdx] <= merge16(srcAddr_reg[chIdx], wd, be);
               SLOT_DST: dstAddr_reg[chIdx] <= merge16(dstAddr_reg[chIdx], wd, be);
               SLOT_CNT: begin
                  elemCnt_reg[chIdx] <= merge16(elemCnt_reg[chIdx], wd, be);
                  elemSize_reg[chIdx] <= merge16(elemCnt_reg[chIdx], wd, be);
               end
               SLOT_SEF: syncFrame_reg[chIdx] <=
                  merge16(syncFrame_reg[chIdx], wd, be);
               SLOT_MODE: mode_reg[chIdx] <= merge16(mode_reg[chIdx], wd, be);
               SLOT_RSRC: rlSrc_reg[chIdx] <= merge16(rlSrc_reg[chIdx], wd, be);
               SLOT_RDST: rlDst_reg[chIdx] <= merge16(rlDst_reg[chIdx], wd, be);
               SLOT_RCNT: rlCnt_reg[chIdx] <= merge16(rlCnt_reg[chIdx], wd, be);
               SLOT_RFRM: if (be[0]) begin
                  rlFrm_reg[chIdx] <= wd[7:0];
               end
               default: ;
            endcase
         end
      end
   end

   // ---------------- transfer engine ----------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         chan_reg <= 3'h0;
         half_reg <= 1'b0;
         req_reg <= '0;
         frameEnd_reg <= 1'b0;
         blockEnd_reg <= 1'b0;
         halfPt_reg <= 1'b0;
         irq_reg <= 6'h00;
      end else begin
         irq_reg <= 6'h00;
         case (state_reg)
            ST_IDLE: begin
               if (grantValid) begin
                  chan_reg <= grantIdx;
                  half_reg <= 1'b0;
                  req_reg <= '{addr: srcAddr_reg[grantIdx], we: 1'b0,
                     data: 16'h0000};
                  state_reg <= ST_READ;
               end
            end
            ST_READ: begin
               if (memReady) begin
                  req_reg <= '{addr: dstAddr_reg[chan_reg], we: 1'b1,
                     data: memRdata};
                  state_reg <= ST_WRITE;
                  if (lastHalf) begin
                     frameEnd_reg <= cntZero;
                     blockEnd_reg <= blockEndNow;
                     halfPt_reg <= curRing & halfPtNow;
                  end
               end
            end
            ST_WRITE: begin
               if (memReady && !lastHalf) begin
                  half_reg <= 1'b1;
                  req_reg <= '{addr: srcAddr_reg[chan_reg], we: 1'b0,
                     data: 16'h0000};
                  state_reg <= ST_READ;
               end else if (memReady) begin
                  irq_reg[chan_reg] <= irqNow;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   assign memValid = (state_reg == ST_READ) | (state_reg == ST_WRITE);
   assign memReq = req_reg;
   assign dmaIrq = irq_reg;

   // shared lines 0..3 carry serial or channel pulses
   wire logic [1:0] muxSel = prioEnable_reg[PR_MUX_LO +: 2];
   assign sharedIrq = (muxSel == MUX_PART) ?
                      {irq_reg[3:2], serialIrq[1:0]} :
                      (muxSel == MUX_ALL) ? irq_reg[3:0] :
                      serialIrq;
endmodule // dma_channel_sequencer
`default_nettype wire

// ===== tb/dma_seq_assertions.sv
// concurrent checks on the sequencer's bus, memory port and interrupts
`timescale 1ns/10ps
`default_nettype none
module dma_seq_assertions
   import dma_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic memValid,
   input wire mem_req_t memReq,
   input wire logic memReady,
   input wire logic [15:0] memRdata,
   input wire logic [15:0] syncEvent,
   input wire logic [3:0] serialIrq,
   input wire logic [5:0] dmaIrq,
   input wire logic [3:0] sharedIrq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_rdAcc;
      memValid && memReady && !memReq.we;
   endsequence
   sequence s_wrAcc;
      memValid && memReady && memReq.we;
   endsequence
   property p_busFirst;
      (avs_read || avs_write) && !$past(avs_read || avs_write)
         |-> avs_waitrequest;
   endproperty
   property p_busDone;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_rdHigh;
      avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000;
   endproperty
   property p_irqPulse;
      dmaIrq != 6'h00 |=> (dmaIrq & $past(dmaIrq)) == 6'h00;
   endproperty
   property p_irqCause;
      dmaIrq != 6'h00 |-> $past(memValid && memReady && memReq.we);
   endproperty
   property p_memHold;
      memValid && !memReady |=> memValid && $stable(memReq);
   endproperty
   property p_rdWr;
      s_rdAcc |=> memValid && memReq.we && memReq.data == $past(memRdata);
   endproperty
   property p_gap;
      s_wrAcc |=> !(memValid && memReq.we);
   endproperty
   property p_sharedReset;
      !$past(resetn) |-> sharedIrq == serialIrq;
   endproperty
   property p_sharedSrc;
      dmaIrq[3:0] == 4'h0 |-> (sharedIrq & ~serialIrq) == 4'h0;
   endproperty
   a_busFirst: assert property (p_busFirst) else $error("no wait cycle");
   a_busDone: assert property (p_busDone) else $error("bus answer late");
   a_rdHigh: assert property (p_rdHigh) else $error("readdata high set");
   a_irqPulse: assert property (p_irqPulse)
      else $error("interrupt longer than one cycle");
   a_irqCause: assert property (p_irqCause)
      else $error("interrupt without final write");
   a_memHold: assert property (p_memHold) else $error("request changed");
   a_rdWr: assert property (p_rdWr) else $error("write does not follow read");
   a_gap: assert property (p_gap) else $error("no idle cycle after element");
   a_sharedReset: assert property (p_sharedReset)
      else $error("shared lines not serial after reset");
   a_sharedSrc: assert property (p_sharedSrc)
      else $error("shared line set without source");
endmodule // dma_seq_assertions
bind dma_channel_sequencer dma_seq_assertions i_chk(.*);
`default_nettype wire

// ===== tb/dma_mem_model.sv
// memory model on the sequencer's memory port, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module dma_mem_model
   import dma_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic slow,
   input wire logic memValid,
   input wire mem_req_t memReq,
   output logic memReady,
   output logic [15:0] memRdata
);
   logic [1:0] waitCnt;
   logic [15:0] lastRd;
   logic isRead;
   assign isRead = memValid && !memReq.we;
   // slow answers take three wait cycles
   assign memReady = memValid && (!slow || waitCnt == 2'h3);
   // a released data line shows the inverse of its last value
   assign memRdata = isRead ? {8'hA5, memReq.addr[7:0]} : ~lastRd;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         waitCnt <= 2'h0;
         lastRd <= 16'h0000;
      end else begin
         waitCnt <= (memValid && !memReady) ? waitCnt + 2'h1 : 2'h0;
         if (isRead && memReady) begin
            lastRd <= memRdata;
         end
      end
   end
endmodule // dma_mem_model
`default_nettype wire

// ===== tb/dma_channel_sequencer_bench.sv
// self-checking bench of the six-channel dma sequencer
`timescale 1ns/10ps
`default_nettype none
module dma_channel_sequencer_bench;
   import dma_seq_pkg::*;
   logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest;
   logic memValid, memReady, slow;
   logic [8:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, serialIrq, sharedIrq;
   logic [15:0] memRdata, syncEvent;
   logic [5:0] dmaIrq;
   mem_req_t memReq;
   int miscompares, checks, irqCnt;
   logic [15:0] wa[$], wd[$];
   dma_channel_sequencer i_dut(.*);
   dma_mem_model i_mem(.*);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (memValid && memReady && memReq.we) begin
         wa.push_back(memReq.addr);
         wd.push_back(memReq.data);
      end
      irqCnt += $countones(dmaIrq);
   end
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [8:0] a, input logic w,
         input logic [15:0] d, output logic [31:0] q);
      int i;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [8:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 16'h0000, q);
      chk(q, exp);
   endtask
   task automatic setch(input logic [2:0] ch, input logic [15:0] v[5]);
      int s;
      for (s = 0; s < 5; s++) wr({ch + 3'h1, 4'(s), 2'h0}, v[s]);
      wa.delete();
      wd.delete();
      irqCnt = 0;
   endtask
   task automatic waitw(input int n);
      int i;
      for (i = 0; i < 400 && wa.size() < n; i++) @(posedge clk_sys);
      if (wa.size() < n) begin
         miscompares++;
         finish_test();
      end
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic t_reset();
      logic [3:0] e[3] = '{4'hF, 4'h3, 4'h0};
      int m;
      rd(OFF_PRIO, 32'h0000);
      wr(9'h1C0, 16'hFFFF);
      rd(9'h1C0, 32'h0000);
      wr(OFF_PRIO, 16'h4000);
      rd(OFF_PRIO, 32'h4000);
      for (m = 0; m < 3; m++) begin
         wr(OFF_PRIO, 16'(m << 6));
         @(negedge clk_sys);
         chk(sharedIrq, e[m]);
      end
   endtask
   task automatic t_index();
      logic [15:0] m[3] = '{16'h410C, 16'h610C, 16'h210C};
      int n[3] = '{1, 2, 0};
      int k, j;
      wr(OFF_EIDXA, 16'h0002);
      wr(OFF_FIDXA, 16'h0010);
      for (k = 0; k < 3; k++) begin
         setch(3'h0, '{16'h0020, 16'h0040, 16'h0002, 16'h0001, m[k]});
         slow <= k[0];
         wr(OFF_PRIO, 16'h0001);
         waitw(6);
         chk(wa.size(), 6);
         for (j = 0; j < 6; j++) begin
            chk(wa[j], 16'h0040 + 2 * j + (j > 2 ? 14 : 0));
            chk(wd[j], 16'hA520 + j);
         end
         chk(irqCnt, n[k]);
         rd(OFF_PRIO, 32'h0000);
      end
   endtask
   task automatic t_prio(input logic [15:0] pr, input logic hi);
      setch(3'h0, '{16'h0000, 16'h0080, 16'h0001, 16'h0000, 16'h0104});
      setch(3'h1, '{16'h0000, 16'h00C0, 16'h0001, 16'h0000, 16'h0104});
      wr(OFF_PRIO, pr);
      waitw(4);
      if (hi) begin
         chk(wa[0], 16'h00C0);
         chk(wa[1], 16'h00C1);
      end else begin
         chk(wa[0][6] ^ wa[1][6], 1);
         chk(wa[1][6] ^ wa[2][6], 1);
      end
   endtask
   task automatic t_sync();
      setch(3'h2, '{16'h0030, 16'h0090, 16'h0000, 16'h1800, 16'h0104});
      wr(OFF_PRIO, 16'h0004);
      repeat (20) @(posedge clk_sys);
      chk(wa.size(), 0);
      syncEvent <= 16'h0002;
      @(posedge clk_sys);
      syncEvent <= 16'h0000;
      waitw(2);
      chk(wa.size(), 2);
      chk(wa[1], 16'h0091);
      chk(wd[1], 16'hA531);
   endtask
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 9'h000;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h3;
      serialIrq = 4'hF;
      syncEvent = 16'h0000;
      slow = 1'b0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_index();
      t_prio(16'h0203, 1'b1);
      t_prio(16'h0003, 1'b0);
      t_sync();
      finish_test();
   end
endmodule // dma_channel_sequencer_bench
`default_nettype wire
